// >>> verilog/idio_decode.sv
// Functional notes
// [RULE1] Each circuit: 24 lines, 8/8/4+4, each selectable
// [RULE2] One, two or four circuit pairs
// [RULE3] Base aligned to 8, 16 or 32
// [RULE4] Answer only own range, 8-bit data
// [RULE5] Switch down means address line one
// [RULE6] Base settable across 000 to 3F0
// [RULE7] Base defaults to 300 hex
// [RULE8] Enable input turns on wait generator
// [RULE9] Wait only during own accesses
// [RULE10] Reset makes every group a high-Z input
// [RULE11] Four locations: three data, one control
// [RULE12] Control word bit7 set, 6/5/2 clear
// [RULE13] Low two bits pick register, upper circuit
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

module idio_decode
  import idio_pkg::*;
#(
  parameter int NUM_PAIRS = 2
) (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rstn,
  // Register port
  input  wire idio_bus_s                     busReq,
  output logic [DATA_W-1:0]                  rdData,
  // Board straps
  input  wire logic [ADDR_W-1:SW_LSB]        baseSwDown,
  input  wire logic                          waitEnable,
  // Bus wait request
  output logic                               ioWait,
  // Port pins
  input  wire logic [2*NUM_PAIRS*PORT_W-1:0] pinIn,
  output logic [2*NUM_PAIRS*PORT_W-1:0]      pinOut,
  output logic [2*NUM_PAIRS*PORT_W-1:0]      pinOe
);

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NCIRC    = 2 * NUM_PAIRS; // see [RULE2]
  localparam int LOW_BITS = 3 + $clog2(NUM_PAIRS); // see [RULE3]
  localparam int NPIN     = NCIRC * PORT_W;
  localparam logic [ADDR_W-1-SW_LSB:0] CMP_MASK =
    (ADDR_W-SW_LSB)'({(ADDR_W-SW_LSB){1'b1}} << (LOW_BITS - SW_LSB)); // see [RULE3]

  typedef struct packed {
    logic [7:0] outA;
    logic [7:0] outB;
    logic [7:0] outC;
    logic [7:0] ctrl;
  } idio_circ_s;

  typedef struct packed {
    idio_circ_s [NCIRC-1:0]  circ;
    logic [NPIN-1:0]         pinMeta;
    logic [NPIN-1:0]         pinSync;
    logic [ADDR_W-1:SW_LSB]  swMeta;
    logic [ADDR_W-1:SW_LSB]  swSync;
    logic                    waitMeta;
    logic                    waitSync;
    logic [DATA_W-1:0]       rdData;
    logic [WAIT_CNT_W-1:0]   waitCnt;
  } idio_state_s;

  idio_state_s st_reg;
  idio_state_s st_next;

  // ----------------------------------------------------------------
  // Data register read with per-group direction
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_port(idio_circ_s c, logic [PORT_W-1:0] pins,
                                           logic [1:0] sel);
    logic [7:0] v;
    v = 8'h00;
    case (sel)
      REG_A:    v = c.ctrl[CTRL_A_IN] ? pins[7:0] : c.outA; // see [RULE1]
      REG_B:    v = c.ctrl[CTRL_B_IN] ? pins[15:8] : c.outB;
      REG_C: begin
        v[7:4] = c.ctrl[CTRL_CHI_IN] ? pins[23:20] : c.outC[7:4];
        v[3:0] = c.ctrl[CTRL_CLO_IN] ? pins[19:16] : c.outC[3:0];
      end
      REG_CTRL: v = c.ctrl; // see [RULE11]
      default:  v = 8'h00;
    endcase
    return v;
  endfunction : read_port

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic                 hit;
  logic [LOW_BITS-3:0]  circIdx;
  logic [1:0]           regSel;
  logic                 access;
  logic                 baseInRange;

  // Switch bit equal to address bit, only above the block size
  assign hit = baseInRange &&
               (((busReq.addr[ADDR_W-1:SW_LSB] ^ st_reg.swSync) & CMP_MASK) == '0); // see [RULE5]
  assign baseInRange = ({st_reg.swSync, 3'h0} <= BASE_MAX); // see [RULE6]
  assign circIdx = busReq.addr[LOW_BITS-1:2]; // see [RULE13]
  assign regSel  = busReq.addr[1:0]; // see [RULE13]
  assign access  = hit && (busReq.wr || busReq.rd); // see [RULE4]

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next          = st_reg;
    st_next.pinMeta  = pinIn;
    st_next.pinSync  = st_reg.pinMeta;
    st_next.swMeta   = baseSwDown;
    st_next.swSync   = st_reg.swMeta;
    st_next.waitMeta = waitEnable;
    st_next.waitSync = st_reg.waitMeta;
    st_next.rdData   = 8'h00; // see [RULE4]
    if (st_reg.waitCnt != '0) begin
      st_next.waitCnt = st_reg.waitCnt - WAIT_CNT_W'(1);
    end
    if (access && st_reg.waitSync) begin
      st_next.waitCnt = WAIT_CYCLES; // see [RULE8] see [RULE9]
    end
    if (hit && busReq.wr) begin
      case (regSel)
        REG_A: st_next.circ[circIdx].outA = busReq.wdata;
        REG_B: st_next.circ[circIdx].outB = busReq.wdata;
        REG_C: st_next.circ[circIdx].outC = busReq.wdata;
        REG_CTRL: begin
          if (busReq.wdata[CTRL_MODE]) begin
            // Only simple I/O words are taken, others are ignored
            if ((busReq.wdata & CTRL_ZERO_MASK) == 8'h00) begin
              st_next.circ[circIdx].ctrl = busReq.wdata; // see [RULE12]
              st_next.circ[circIdx].outA = 8'h00;
              st_next.circ[circIdx].outB = 8'h00;
              st_next.circ[circIdx].outC = 8'h00;
            end
          end else begin
            // Single bit set or clear on the third port
            st_next.circ[circIdx].outC[busReq.wdata[3:1]] = busReq.wdata[0];
          end
        end
        default: st_next.circ[circIdx].outA = st_reg.circ[circIdx].outA;
      endcase
    end
    if (hit && busReq.rd) begin
      st_next.rdData = read_port(st_reg.circ[circIdx],
                                 st_reg.pinSync[int'(circIdx)*PORT_W +: PORT_W],
                                 regSel); // see [RULE11]
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      for (int i = 0; i < NCIRC; i++) begin
        st_reg.circ[i].ctrl <= CTRL_RESET; // see [RULE10]
      end
      st_reg.swMeta <= BASE_RESET[ADDR_W-1:SW_LSB]; // see [RULE7]
      st_reg.swSync <= BASE_RESET[ADDR_W-1:SW_LSB]; // see [RULE7]
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdData = st_reg.rdData;
  assign ioWait = (st_reg.waitCnt != '0);

  for (genvar g = 0; g < NCIRC; g++) begin : g_pins
    assign pinOut[g*PORT_W +: PORT_W] = {st_reg.circ[g].outC, st_reg.circ[g].outB,
                                         st_reg.circ[g].outA};
    assign pinOe[g*PORT_W +: PORT_W] = {{4{~st_reg.circ[g].ctrl[CTRL_CHI_IN]}},
                                        {4{~st_reg.circ[g].ctrl[CTRL_CLO_IN]}},
                                        {8{~st_reg.circ[g].ctrl[CTRL_B_IN]}},
                                        {8{~st_reg.circ[g].ctrl[CTRL_A_IN]}}}; // see [RULE1]
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_own_access;
    hit && (busReq.rd || busReq.wr) && st_reg.waitSync;
  endsequence

  sequence s_wait_run;
    ioWait [*8];
  endsequence

  property p_miss_reads_zero;
    (busReq.rd && !hit) |=> (rdData == 8'h00);
  endproperty
  a_miss_reads_zero: assert property (p_miss_reads_zero) // see [RULE4]
    else $error("read outside range returned data");

  property p_wait_only_own;
    $rose(ioWait) |-> $past(access);
  endproperty
  a_wait_only_own: assert property (p_wait_only_own) // see [RULE9]
    else $error("wait raised without own access");

  property p_wait_length;
    s_own_access |=> s_wait_run;
  endproperty
  a_wait_length: assert property (p_wait_length) // see [RULE8]
    else $error("wait too short after own access");

  property p_no_wait_disabled;
    (!ioWait && !st_reg.waitSync) |=> !ioWait;
  endproperty
  a_no_wait_disabled: assert property (p_no_wait_disabled) // see [RULE8]
    else $error("wait raised while generator disabled");

  property p_all_output;
    (hit && busReq.wr && regSel == REG_CTRL && circIdx == '0 && busReq.wdata == 8'h80)
      |=> (pinOe[PORT_W-1:0] == {PORT_W{1'b1}});
  endproperty
  a_all_output: assert property (p_all_output) // see [RULE12]
    else $error("control 80 did not make all outputs");

  property p_bad_ctrl_ignored;
    (hit && busReq.wr && regSel == REG_CTRL && circIdx == '0 && busReq.wdata[7]
      && busReq.wdata[6:5] != 2'h0) |=> $stable(pinOe[PORT_W-1:0]);
  endproperty
  a_bad_ctrl_ignored: assert property (p_bad_ctrl_ignored) // see [RULE12]
    else $error("non simple control word took effect");

  property p_ctrl_readback;
    (hit && busReq.rd && regSel == REG_CTRL && circIdx == '0)
      |=> (rdData == $past(st_reg.circ[0].ctrl));
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback) // see [RULE11]
    else $error("control readback mismatch");

  property p_input_read;
    (hit && busReq.rd && regSel == REG_A && circIdx == '0 && st_reg.circ[0].ctrl[CTRL_A_IN])
      |=> (rdData == $past(st_reg.pinSync[7:0]));
  endproperty
  a_input_read: assert property (p_input_read) // see [RULE1]
    else $error("input group read mismatch");

  property p_reset_inputs;
    !$past(rstn) |-> (pinOe == '0);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) // see [RULE10]
    else $error("pins driven after reset");

  property p_write_out;
    (hit && busReq.wr && regSel == REG_B && circIdx == '0)
      |=> (pinOut[15:8] == $past(busReq.wdata));
  endproperty
  a_write_out: assert property (p_write_out) // see [RULE13]
    else $error("second group write not on pins");

endmodule : idio_decode

// >>> verilog/idio_pkg.sv
package idio_pkg;

  // ----------------------------------------------------------------
  // Bus and port geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int SW_LSB = 3;
  localparam int PORT_W = 24;

  // ----------------------------------------------------------------
  // Register select within one port circuit
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_A    = 2'h0;
  localparam logic [1:0] REG_B    = 2'h1;
  localparam logic [1:0] REG_C    = 2'h2;
  localparam logic [1:0] REG_CTRL = 2'h3;

  // ----------------------------------------------------------------
  // Control word fields, a one in a direction bit means input
  // ----------------------------------------------------------------
  localparam int CTRL_MODE   = 7;
  localparam int CTRL_A_IN   = 4;
  localparam int CTRL_CHI_IN = 3;
  localparam int CTRL_B_IN   = 1;
  localparam int CTRL_CLO_IN = 0;
  localparam logic [7:0] CTRL_ZERO_MASK = 8'h64;
  localparam logic [7:0] CTRL_RESET     = 8'h9b;

  // ----------------------------------------------------------------
  // Decoder settings
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] BASE_RESET = 10'h300;
  localparam logic [ADDR_W-1:0] BASE_MAX   = 10'h3f0;

  // ----------------------------------------------------------------
  // Wait-state timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int WAIT_TIME_NS  = 120;
  localparam int WAIT_CNT_W    = 8;
  localparam logic [WAIT_CNT_W-1:0] WAIT_CYCLES =
    WAIT_CNT_W'((WAIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } idio_bus_s;

endpackage : idio_pkg

// >>> verification/idio_pin_model.sv
`timescale 1ns/1ps

module idio_pin_model
  import idio_pkg::*;
#(
  parameter int NCIRC = 2
) (
  // Clock
  input  wire logic                    sys_clk,
  // Board side
  input  wire logic [NCIRC*PORT_W-1:0] pinOut,
  input  wire logic [NCIRC*PORT_W-1:0] pinOe,
  // Far-side sources
  input  wire logic [NCIRC*PORT_W-1:0] extVal,
  input  wire logic [NCIRC*PORT_W-1:0] extDrive,
  output logic      [NCIRC*PORT_W-1:0] pinIn
);
  logic [NCIRC*PORT_W-1:0] floatPat = '0;

  // Unpulled, undriven lines wander every cycle
  always_ff @(posedge sys_clk) begin
    floatPat <= ~floatPat;
  end

  // Driven lines read back, released lines follow the far side
  always_comb begin
    pinIn = (pinOe & pinOut) | (~pinOe & extDrive & extVal) | (~pinOe & ~extDrive & floatPat);
  end
endmodule : idio_pin_model

// >>> verification/testbench.sv
`timescale 1ns/1ps

module testbench import idio_pkg::*;;
  localparam int NP = 1;
  localparam int NW = 2*NP*PORT_W;
  logic          sys_clk, rstn, waitEnable, ioWait, rdSeen;
  idio_bus_s     busReq;
  logic [7:0]    rdData, c, d;
  logic [9:3]    baseSwDown, sw;
  logic [9:0]    base;
  logic [NW-1:0] pinIn, pinOut, pinOe, extVal, extDrive;
  logic [7:0]    expQ[$];
  logic [7:0]    bad[3] = '{8'hc0, 8'ha0, 8'h84};
  int            n_mismatch, cmp_count, seed, k;

  idio_decode #(.NUM_PAIRS(NP)) dut (.sys_clk(sys_clk), .rstn(rstn), .busReq(busReq),
    .rdData(rdData), .baseSwDown(baseSwDown), .waitEnable(waitEnable), .ioWait(ioWait),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
  idio_pin_model #(.NCIRC(2*NP)) model (.sys_clk(sys_clk), .pinOut(pinOut), .pinOe(pinOe),
    .extVal(extVal), .extDrive(extDrive), .pinIn(pinIn));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic check(input logic [NW-1:0] got, input logic [NW-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    busReq.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    expQ.push_back(e);
    @(posedge sys_clk);
    busReq.rd <= 1'b0;
  endtask : rd

  task automatic wait_len(input logic [7:0] e);
    int n;
    n = 0;
    repeat (40) begin
      @(negedge sys_clk);
      if (ioWait === 1'b1) n++;
    end
    check(NW'(n), NW'(e));
  endtask : wait_len

  task automatic finish_test();
    $display("TB: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk) rdSeen <= busReq.rd;
  always @(negedge sys_clk) begin
    if (rdSeen === 1'b1) begin
      if (expQ.size() == 0) check(NW'(rdData), '1);
      else check(NW'(rdData), NW'(expQ.pop_front()));
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 3945; n_mismatch = 0; cmp_count = 0; rstn = 1'b0; busReq = '0;
    baseSwDown = 7'h60; waitEnable = 1'b0; extVal = '0; extDrive = '0; base = BASE_RESET;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(pinOe, '0);
    check(pinOut, '0);
    rd(base + 10'h3, CTRL_RESET);
    rd(base + 10'h7, CTRL_RESET);
    for (k = 0; k < 16; k++) begin
      c = 8'h80 | {3'b0, k[3], k[2], 1'b0, k[1], k[0]};
      wr(base + 10'h7, c);
      @(negedge sys_clk);
      check(pinOe, {{4{~k[2]}}, {4{~k[0]}}, {8{~k[1]}}, {8{~k[3]}}, 24'h0});
      rd(base + 10'h7, c);
    end
    wr(base + 10'h3, 8'h80);
    d = 8'($random(seed));
    wr(base, d);
    wr(base + 10'h1, ~d);
    wr(base + 10'h2, d ^ 8'h5a);
    @(negedge sys_clk);
    check(pinOut[23:0], {d ^ 8'h5a, ~d, d});
    rd(base + 10'h1, ~d);
    for (k = 0; k < 3; k++) wr(base + 10'h3, bad[k]);
    rd(base + 10'h3, 8'h80);
    rd(base, d);
    wr(base + 10'h3, 8'h80);
    rd(base + 10'h2, 8'h00);
    // Single bit set on the third port, then clear it again
    wr(base + 10'h3, 8'h0f);
    rd(base + 10'h2, 8'h80);
    wr(base + 10'h3, 8'h0e);
    rd(base + 10'h2, 8'h00);
    wr(base + 10'h3, CTRL_RESET);
    extDrive <= '1;
    extVal <= NW'({$random(seed), $random(seed)});
    repeat (4) @(posedge sys_clk);
    rd(base, extVal[7:0]);
    rd(base + 10'h2, extVal[23:16]);
    rd(base + 10'h8, 8'h00);
    wr(base + 10'hb, 8'h80);
    @(negedge sys_clk);
    check(pinOe, '0);
    for (k = 0; k < 3; k++) begin
      sw = (k == 0) ? 7'h00 : (k == 1) ? 7'h7e : 7'($random(seed)) & 7'h7d;
      baseSwDown <= sw;
      repeat (3) @(posedge sys_clk);
      base = {sw, 3'b000};
      rd(base + 10'h3, CTRL_RESET);
      rd({~sw, 3'b000} + 10'h3, 8'h00);
    end
    wr(base, 8'h11);
    wait_len(8'h00);
    waitEnable <= 1'b1;
    repeat (3) @(posedge sys_clk);
    wr(base + 10'h4, 8'h11);
    wait_len(WAIT_CYCLES);
    rd({~sw, 3'b000}, 8'h00);
    wait_len(8'h00);
    repeat (3) @(posedge sys_clk);
    finish_test();
  end
endmodule : testbench
